/* File: core/aio_cfg.svh */
// constants for the automatic block transfer engine
`ifndef AIO_CFG_SVH
`define AIO_CFG_SVH
`define AIO_OP_WORD_IN 8'h50
`define AIO_OP_WORD_OUT 8'h60
`define AIO_OP_BYTE_IN 8'h54
`define AIO_OP_BYTE_OUT 8'h64
`define AIO_OP_MSB 15
`define AIO_OP_LSB 8
`define AIO_DEV_MSB 7
`define AIO_DEV_LSB 0
`define AIO_PC_EXIT 16'h0003
`define AIO_PC_NEXT 16'h0004
`define AIO_ONE 16'h0001
`define AIO_ZERO 16'h0000
`define AIO_QUARTER_CYCLES 2'h1
`endif

/* File: core/aio_pkg.sv */
// types for the automatic block transfer engine
`default_nettype none
package aio_pkg;
    typedef logic [15:0] aio_word_t;
    typedef enum logic [1:0] {
        AIO_WORD_IN,
        AIO_WORD_OUT,
        AIO_BYTE_IN,
        AIO_BYTE_OUT
    } aio_kind_e;
endpackage
`default_nettype wire

/* File: core/aio_mem_if.sv */
// memory request channel between engine and its memory port
`default_nettype none
interface aio_mem_if;
    logic req;
    logic we;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic ack;
    modport master (output req, output we, output addr, output wdata,
                    input rdata, input ack);
    modport slave (input req, input we, input addr, input wdata,
                   output rdata, output ack);
endinterface
`default_nettype wire

/* File: core/aio_mem_port.sv */
// registered memory port: drives top level memory pins
`default_nettype none
`include "aio_cfg.svh"
module aio_mem_port
(
    input wire logic i_clk,
    input wire logic i_reset_n,
    aio_mem_if.slave m,
    output logic o_req,
    output logic o_we,
    output logic [15:0] o_addr,
    output logic [15:0] o_wdata,
    input wire logic i_ack,
    input wire logic [15:0] i_rdata
);
    logic busy_q;
    assign m.ack = i_ack & busy_q;
    assign m.rdata = i_rdata;
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            busy_q <= 1'b0;
            o_req <= 1'b0;
            o_we <= 1'b0;
            o_addr <= `AIO_ZERO;
            o_wdata <= `AIO_ZERO;
        end
        else if (m.req && !busy_q)
        begin
            busy_q <= 1'b1;
            o_req <= 1'b1;
            o_we <= m.we;
            o_addr <= m.addr;
            o_wdata <= m.wdata;
        end
        else if (busy_q && i_ack)
        begin
            busy_q <= 1'b0;
            o_req <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* File: core/aio_engine.sv */
// automatic i/o block transfer execution engine
//
// Summary of operation
// - In-line use does the same count, pointer and data work as interrupt use.
// - In-line with nonzero new count, the next pc is P plus four.
// - In-line with zero new count, the next pc is P plus three.
// - Interrupt use with zero new count pulses the completion echo.
// - Word input bumps count and pointer then stores a device word there.
// - Word output bumps count and pointer then sends that memory word.
// - Byte input bumps count and pointer then stores a device byte there.
// - Byte output bumps count and pointer then sends that memory byte.
// - Both words after the instruction are incremented and written back.
// - Byte input keeps the other byte of the addressed word intact.
// - Outputs never write the data location they read.
// - Opcode sits in bits 15..8, device and function in bits 7..0.
// - Count starts at minus length, pointer one below first item.
// - One item costs four memory cycles, four and a quarter cycles.
// - Byte forms treat the pointer as a byte address, odd or even start.
`default_nettype none
`include "aio_cfg.svh"
module aio_engine
    import aio_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_start,
    input wire logic i_inline,
    input wire aio_pkg::aio_word_t i_pc,
    output logic o_busy,
    output logic o_done,
    output logic o_illegal,
    output aio_pkg::aio_word_t o_next_pc,
    output logic o_pc_load,
    output logic o_mem_req,
    output logic o_mem_we,
    output aio_pkg::aio_word_t o_mem_addr,
    output aio_pkg::aio_word_t o_mem_wdata,
    input wire logic i_mem_ack,
    input wire aio_pkg::aio_word_t i_mem_rdata,
    output logic o_io_rd,
    output logic o_io_wr,
    output logic [7:0] o_io_dev,
    output aio_pkg::aio_word_t o_io_wdata,
    input wire aio_pkg::aio_word_t i_io_rdata,
    output logic o_echo
);
    import aio_pkg::*;

    typedef enum logic [3:0] {
        ST_IDLE, ST_FETCH, ST_IOWAIT, ST_CNT_RD, ST_CNT_WR, ST_PTR_RD,
        ST_PTR_WR, ST_DATA_RD, ST_DATA_WR, ST_FINISH
    } aio_state_e;

    aio_mem_if mem ();

    aio_state_e state_q, state_d;
    aio_word_t pc_q, instr_q, cnt_q, ptr_q, data_q;
    logic inline_q;
    logic [1:0] quarter_q;
    logic illegal_q, done_q, echo_q, pcl_q, io_rd_q, io_wr_q;
    logic busy_q;
    aio_word_t next_pc_q, io_wdata_q;
    logic [7:0] io_dev_q;

    wire [7:0] opcode = instr_q[`AIO_OP_MSB:`AIO_OP_LSB];
    wire [7:0] dev = instr_q[`AIO_DEV_MSB:`AIO_DEV_LSB];
    wire is_wi = opcode == `AIO_OP_WORD_IN;
    wire is_wo = opcode == `AIO_OP_WORD_OUT;
    wire is_bi = opcode == `AIO_OP_BYTE_IN;
    wire is_bo = opcode == `AIO_OP_BYTE_OUT;
    wire legal = is_wi | is_wo | is_bi | is_bo;
    wire is_byte = is_bi | is_bo;
    wire is_in = is_wi | is_bi;
    wire [15:0] rd_inc = mem.rdata + `AIO_ONE;
    wire cnt_zero = cnt_q == `AIO_ZERO;
    wire [15:0] data_addr = is_byte ? {1'b0, ptr_q[15:1]} : ptr_q;
    wire low_half = ptr_q[0];
    wire [15:0] merged = low_half ? {data_q[15:8], i_io_rdata[7:0]}
                                  : {i_io_rdata[7:0], data_q[7:0]};
    wire [15:0] out_byte = low_half ? {8'h00, data_q[7:0]}
                                    : {8'h00, data_q[15:8]};
    wire ack = mem.ack;
    wire [15:0] p1 = pc_q + `AIO_ONE;
    wire [15:0] p2 = p1 + `AIO_ONE;

    always_comb
    begin
        state_d = state_q;
        mem.req = 1'b0;
        mem.we = 1'b0;
        mem.addr = `AIO_ZERO;
        mem.wdata = `AIO_ZERO;
        unique case (state_q)
            ST_IDLE:
                if (i_start)
                    state_d = ST_FETCH;
            ST_FETCH:
            begin
                mem.req = 1'b1;
                mem.addr = pc_q;
                if (ack)
                    state_d = ST_IOWAIT;
            end
            // extra quarter on the i/o fetch
            ST_IOWAIT:
                if (quarter_q == `AIO_QUARTER_CYCLES)
                    state_d = legal ? ST_CNT_RD : ST_FINISH;
            ST_CNT_RD:
            begin
                mem.req = 1'b1;
                mem.addr = p1;
                if (ack)
                    state_d = ST_CNT_WR;
            end
            ST_CNT_WR:
            begin
                mem.req = 1'b1;
                mem.we = 1'b1;
                mem.addr = p1;
                mem.wdata = cnt_q;
                if (ack)
                    state_d = ST_PTR_RD;
            end
            ST_PTR_RD:
            begin
                mem.req = 1'b1;
                mem.addr = p2;
                if (ack)
                    state_d = ST_PTR_WR;
            end
            ST_PTR_WR:
            begin
                mem.req = 1'b1;
                mem.we = 1'b1;
                mem.addr = p2;
                mem.wdata = ptr_q;
                if (ack)
                    state_d = (is_in && !is_byte) ? ST_DATA_WR : ST_DATA_RD;
            end
            ST_DATA_RD:
            begin
                mem.req = 1'b1;
                mem.addr = data_addr;
                if (ack)
                    state_d = is_in ? ST_DATA_WR : ST_FINISH;
            end
            ST_DATA_WR:
            begin
                mem.req = 1'b1;
                mem.we = 1'b1;
                mem.addr = data_addr;
                mem.wdata = is_byte ? merged : i_io_rdata;
                if (ack)
                    state_d = ST_FINISH;
            end
            ST_FINISH:
                state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            state_q <= ST_IDLE;
            busy_q <= 1'b0;
            pc_q <= `AIO_ZERO;
            instr_q <= `AIO_ZERO;
            cnt_q <= `AIO_ZERO;
            ptr_q <= `AIO_ZERO;
            data_q <= `AIO_ZERO;
            inline_q <= 1'b0;
            quarter_q <= 2'h0;
        end
        else
        begin
            state_q <= state_d;
            // busy tracks state_q exactly but leaves from a flop
            busy_q <= state_d != ST_IDLE;
            quarter_q <= (state_q == ST_IOWAIT) ? quarter_q + 2'h1 : 2'h0;
            if (state_q == ST_IDLE && i_start)
            begin
                pc_q <= i_pc;
                inline_q <= i_inline;
            end
            if (ack && state_q == ST_FETCH)
                instr_q <= mem.rdata;
            if (ack && state_q == ST_CNT_RD)
                cnt_q <= rd_inc;
            // pointer bumped as byte or word address
            if (ack && state_q == ST_PTR_RD)
                ptr_q <= rd_inc;
            if (ack && state_q == ST_DATA_RD)
                data_q <= mem.rdata;
        end
    end

    wire fin = state_q == ST_FINISH;
    wire fin_ok = fin && legal;

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            done_q <= 1'b0;
            echo_q <= 1'b0;
            pcl_q <= 1'b0;
            illegal_q <= 1'b0;
            next_pc_q <= `AIO_ZERO;
            io_rd_q <= 1'b0;
            io_wr_q <= 1'b0;
            io_dev_q <= 8'h00;
            io_wdata_q <= `AIO_ZERO;
        end
        else
        begin
            done_q <= fin;
            illegal_q <= fin && !legal;
            echo_q <= fin_ok && !inline_q && cnt_zero;
            pcl_q <= fin_ok && inline_q;
            if (fin_ok && inline_q)
                next_pc_q <= pc_q + (cnt_zero ? `AIO_PC_EXIT : `AIO_PC_NEXT);
            io_dev_q <= dev;
            // input strobe pulses the cycle after the data store is acknowledged
            io_rd_q <= state_q == ST_DATA_WR && ack;
            io_wr_q <= fin_ok && !is_in;
            if (fin_ok && !is_in)
                io_wdata_q <= is_byte ? out_byte : data_q;
        end
    end

    assign o_busy = busy_q;
    assign o_done = done_q;
    assign o_illegal = illegal_q;
    assign o_echo = echo_q;
    assign o_pc_load = pcl_q;
    assign o_next_pc = next_pc_q;
    assign o_io_rd = io_rd_q;
    assign o_io_wr = io_wr_q;
    assign o_io_dev = io_dev_q;
    assign o_io_wdata = io_wdata_q;

    aio_mem_port u_port (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .m(mem),
        .o_req(o_mem_req),
        .o_we(o_mem_we),
        .o_addr(o_mem_addr),
        .o_wdata(o_mem_wdata),
        .i_ack(i_mem_ack),
        .i_rdata(i_mem_rdata)
    );
endmodule
`default_nettype wire

/* File: bench/aio_engine_properties.sv */
// port assertions for the block transfer engine
`default_nettype none
module aio_chk
    import aio_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_start,
    input wire aio_pkg::aio_word_t i_pc,
    input wire logic o_busy,
    input wire logic o_echo,
    input wire logic o_pc_load,
    input wire aio_pkg::aio_word_t o_next_pc,
    input wire logic o_mem_req,
    input wire logic o_mem_we,
    input wire aio_pkg::aio_word_t o_mem_addr,
    input wire aio_pkg::aio_word_t o_mem_wdata,
    input wire logic i_mem_ack,
    input wire aio_pkg::aio_word_t i_mem_rdata
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [2:0] acc_q;
    aio_word_t pc_q, cnt_q, ptr_q, ins_q;
    wire aio_word_t ea = acc_q == 3'h0 ? pc_q :
        acc_q < 3'h3 ? pc_q + 16'h0001 : pc_q + 16'h0002;
    // byte forms address the word holding the byte
    wire aio_word_t pn = ptr_q + 16'h0001;
    wire aio_word_t da = ins_q[10] ? pn >> 1 : pn;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    // access count since start, with the words read on the way
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            {acc_q, pc_q, cnt_q, ptr_q, ins_q} <= '0;
        else if (i_start && !o_busy)
        begin
            acc_q <= 3'h0;
            pc_q <= i_pc;
        end
        else if (o_mem_req && i_mem_ack)
        begin
            acc_q <= acc_q + 3'h1;
            if (acc_q == 3'h0) ins_q <= i_mem_rdata;
            if (acc_q == 3'h1) cnt_q <= i_mem_rdata;
            if (acc_q == 3'h3) ptr_q <= i_mem_rdata;
        end
    end
    chk_access_addr: assert property (o_mem_req && acc_q < 3'h5
        |-> o_mem_addr == ea) else $error("access address wrong");
    chk_access_dir: assert property (o_mem_req && acc_q < 3'h5
        |-> o_mem_we == (acc_q == 3'h2 || acc_q == 3'h4))
        else $error("access direction wrong");
    chk_count_wb: assert property (o_mem_req && acc_q == 3'h2
        |-> o_mem_wdata == cnt_q + 16'h0001) else $error("count bad");
    chk_ptr_wb: assert property (o_mem_req && acc_q == 3'h4
        |-> o_mem_wdata == pn) else $error("pointer bad");
    chk_data_addr: assert property (o_mem_req && acc_q == 3'h5
        |-> o_mem_addr == da) else $error("data address wrong");
    chk_out_nowrite: assert property (o_mem_req && acc_q > 3'h4
        && ins_q[13] |-> !o_mem_we) else $error("output wrote memory");
    chk_echo_zero: assert property (o_echo
        |-> cnt_q == 16'hffff && !o_pc_load) else $error("echo wrong");
    chk_next_pc: assert property (o_pc_load |-> o_next_pc ==
        pc_q + (cnt_q == 16'hffff ? 16'h0003 : 16'h0004))
        else $error("next pc wrong");
    chk_req_hold: assert property (o_mem_req && !i_mem_ack
        |=> o_mem_req && $stable(o_mem_addr)) else $error("request dropped");
    chk_fetch_gap: assert property (o_mem_req && i_mem_ack
        && acc_q == 3'h0 ##1 ins_q[14] |-> !o_mem_req [*3] ##1 o_mem_req)
        else $error("fetch wait wrong");
    cover property (o_echo);
    cover property (o_pc_load && o_next_pc == pc_q + 16'h0003);
    cover property (o_mem_req && o_mem_we && acc_q == 3'h6);
endmodule
`default_nettype wire

/* File: bench/aio_far_model.sv */
// memory and peripheral model on the far side of the engine
`default_nettype none
module aio_far_model
(
    input wire logic i_clk,
    input wire logic [1:0] i_lat,
    input wire logic i_req,
    input wire logic i_we,
    input wire logic [15:0] i_addr,
    input wire logic [15:0] i_wdata,
    output logic o_ack,
    output logic [15:0] o_rdata,
    input wire logic i_io_wr,
    input wire logic [7:0] i_io_dev,
    input wire logic [15:0] i_io_wdata
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] mem [0:65535];
    logic [1:0] wait_q = 2'h0;
    logic [15:0] out_q = 16'h0000;
    logic [7:0] dev_q = 8'h00;
    initial o_ack = 1'b0;
    initial o_rdata = 16'h0000;
    always @(posedge i_clk)
    begin
        o_ack <= 1'b0;
        // idle bus toggles so a stale word never looks valid
        o_rdata <= ~o_rdata;
        if (i_req && !o_ack && wait_q != i_lat)
            wait_q <= wait_q + 2'h1;
        else if (i_req && !o_ack)
        begin
            wait_q <= 2'h0;
            o_ack <= 1'b1;
            if (i_we)
                mem[i_addr] <= i_wdata;
            else
                o_rdata <= mem[i_addr];
        end
        if (i_io_wr)
        begin
            out_q <= i_io_wdata;
            dev_q <= i_io_dev;
        end
    end
endmodule
`default_nettype wire

/* File: bench/tb_top.sv */
// bench top: runs the engine against the far side model
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic i_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic i_start = 1'b0;
    logic i_inline = 1'b0;
    logic [15:0] i_pc = 16'h0000;
    logic [15:0] i_io_rdata = 16'h0000;
    logic [1:0] lat = 2'h0;
    logic sd = 1'b0;
    logic se = 1'b0;
    logic sl = 1'b0;
    logic sr = 1'b0;
    logic si = 1'b0;
    logic o_busy, o_done, o_pc_load, o_mem_req, o_mem_we, i_mem_ack;
    logic o_io_wr, o_echo, o_io_rd, o_illegal;
    logic [15:0] o_next_pc, o_mem_addr, o_mem_wdata, i_mem_rdata, o_io_wdata;
    logic [7:0] o_io_dev;
    int fails = 0;
    int tests_run = 0;
    initial forever #12.5 i_clk = ~i_clk;
    aio_engine u_dut (.i_clk, .i_reset_n, .i_start, .i_inline, .i_pc,
        .o_busy, .o_done, .o_illegal, .o_next_pc, .o_pc_load, .o_mem_req,
        .o_mem_we, .o_mem_addr, .o_mem_wdata, .i_mem_ack, .i_mem_rdata,
        .o_io_rd, .o_io_wr, .o_io_dev, .o_io_wdata, .i_io_rdata, .o_echo);
    aio_far_model u_far (.i_clk, .i_lat(lat), .i_req(o_mem_req),
        .i_we(o_mem_we), .i_addr(o_mem_addr), .i_wdata(o_mem_wdata),
        .o_ack(i_mem_ack), .o_rdata(i_mem_rdata), .i_io_wr(o_io_wr),
        .i_io_dev(o_io_dev), .i_io_wdata(o_io_wdata));
    // pulses last one cycle, so latch them; a start clears them
    always @(posedge i_clk)
    begin
        sd <= !i_start && (sd || o_done);
        se <= !i_start && (se || o_echo);
        sl <= !i_start && (sl || o_pc_load);
        sr <= !i_start && (sr || o_io_rd);
        si <= !i_start && (si || o_illegal);
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            fails++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic test_done(input int extra);
        fails += extra;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic run(input logic [15:0] ins, c, a, p, input logic inl);
        // count is minus length, pointer one below
        u_far.mem[p] = ins;
        u_far.mem[p + 16'h0001] = c;
        u_far.mem[p + 16'h0002] = a;
        {i_start, i_inline, i_pc} = {1'b1, inl, p};
        @(negedge i_clk);
        i_start = 1'b0;
        chk({15'h0000, o_busy}, 16'h0001);
        repeat (100) if (!sd) @(negedge i_clk);
        if (!sd) test_done(1);
        chk({15'h0000, o_busy}, 16'h0000);
    endtask
    task automatic t_word_in();
        lat = 2'h0;
        i_io_rdata = 16'hbeef;
        run(16'h5012, 16'hfffe, 16'h007f, 16'h0010, 1'b1);
        chk(u_far.mem[16'h0080], 16'hbeef);
        chk(u_far.mem[16'h0011], 16'hffff);
        chk(u_far.mem[16'h0012], 16'h0080);
        chk(o_next_pc, 16'h0014);
        chk({13'h0000, sr, sl, se}, 16'h0006);
        $display("word in test ended");
    endtask
    task automatic t_word_out();
        lat = 2'h2;
        u_far.mem[16'h0090] = 16'h1234;
        run(16'h6034, 16'hffff, 16'h008f, 16'h0020, 1'b0);
        chk(u_far.out_q, 16'h1234);
        chk(u_far.mem[16'h0090], 16'h1234);
        chk(u_far.mem[16'h0021], 16'h0000);
        chk({8'h00, u_far.dev_q}, 16'h0034);
        chk({13'h0000, sr, sl, se}, 16'h0001);
        $display("word out test ended");
    endtask
    task automatic t_byte_in();
        lat = 2'h1;
        u_far.mem[16'h00a0] = 16'h1122;
        i_io_rdata = 16'h77cc;
        run(16'h5438, 16'hffff, 16'h013f, 16'h0030, 1'b1);
        chk(u_far.mem[16'h00a0], 16'hcc22);
        chk(o_next_pc, 16'h0033);
        chk({13'h0000, sr, sl, se}, 16'h0006);
        i_io_rdata = 16'h55dd;
        run(16'h5438, 16'hffff, 16'h0140, 16'h0030, 1'b1);
        chk(u_far.mem[16'h00a0], 16'hccdd);
        $display("byte in test ended");
    endtask
    task automatic t_byte_out();
        lat = 2'h3;
        u_far.mem[16'h0000] = 16'h9a5b;
        run(16'h6441, 16'hfffe, 16'hffff, 16'h0040, 1'b0);
        chk(u_far.out_q, 16'h009a);
        chk(u_far.mem[16'h0042], 16'h0000);
        chk(u_far.mem[16'h0000], 16'h9a5b);
        chk({13'h0000, sr, sl, se}, 16'h0000);
        $display("byte out test ended");
    endtask
    task automatic t_illegal();
        lat = 2'h0;
        run(16'h3012, 16'hfffe, 16'h00ff, 16'h0050, 1'b1);
        chk({13'h0000, si, sl, se}, 16'h0004);
        chk(u_far.mem[16'h0051], 16'hfffe);
        $display("illegal opcode test ended");
    endtask
    task automatic t_reset();
        lat = 2'h3;
        u_far.mem[16'h0060] = 16'h6034;
        {i_start, i_inline, i_pc} = {1'b1, 1'b0, 16'h0060};
        @(negedge i_clk);
        i_start = 1'b0;
        repeat (4) @(negedge i_clk);
        chk({14'h0000, o_busy, o_mem_req}, 16'h0003);
        i_reset_n = 1'b0;
        #1;
        chk({14'h0000, o_busy, o_mem_req}, 16'h0000);
        repeat (2) @(negedge i_clk);
        i_reset_n = 1'b1;
        @(negedge i_clk);
        t_word_in();
        $display("reset test ended");
    endtask
    initial
    begin
        repeat (8) @(negedge i_clk);
        i_reset_n = 1'b1;
        @(negedge i_clk);
        t_word_in();
        t_word_out();
        t_byte_in();
        t_byte_out();
        t_illegal();
        t_reset();
        test_done(0);
    end
endmodule
bind aio_engine aio_chk u_chk (.i_clk, .i_reset_n, .i_start, .i_pc, .o_busy,
    .o_echo, .o_pc_load, .o_next_pc, .o_mem_req, .o_mem_we, .o_mem_addr,
    .o_mem_wdata, .i_mem_ack, .i_mem_rdata);
`default_nettype wire
